// ---- hdl/ftsr_pkg.sv ----
package ftsr_pkg;

  // Array geometry
  localparam int ADDR_W   = 18;
  localparam int LANES    = 4;
  localparam int LANE_W   = 8;
  localparam int DATA_W   = LANES * LANE_W;
  localparam int DEPTH    = 1 << ADDR_W;
  localparam int BURST_W  = 2;
  localparam int CELL_W   = LANE_W + 1;

  // Reset values
  localparam logic [1:0]       RST_BURST    = 2'h0;
  localparam logic [ADDR_W-3:0] RST_ADDR_HI = '0;
  localparam logic [LANES-1:0] RST_BYTE_SEL = 4'hf;
  localparam logic             RST_ACTIVE   = 1'h0;
  localparam logic             RST_WRITE    = 1'h0;
  localparam logic             RST_LOW      = 1'h0;
  localparam logic             RST_HIGH     = 1'h1;

  // Asynchronous input vector positions
  localparam int ASY_SLEEP = 0;
  localparam int ASY_OE    = 1;
  localparam int ASY_MODE  = 2;
  localparam int ASY_N     = 3;
  localparam logic [ASY_N-1:0] RST_ASYNC = 3'h6;

  // Scan input vector positions
  localparam int SCN_TCK = 0;
  localparam int SCN_TMS = 1;
  localparam int SCN_TDI = 2;
  localparam int SCN_N   = 3;
  localparam logic [SCN_N-1:0] RST_SCAN = 3'h0;

  // Burst order strap levels
  localparam logic MODE_LINEAR = 1'h0;

  // Sleep sequencer, Gray coded
  typedef enum logic [1:0] {
    SLP_AWAKE  = 2'h0,
    SLP_ENTER  = 2'h1,
    SLP_ASLEEP = 2'h3,
    SLP_EXIT   = 2'h2
  } ftsr_sleep_t;

endpackage

// ---- hdl/ftsr_burst_ctr.sv ----
module ftsr_burst_ctr
  import ftsr_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  // Control
  input  wire logic               load,
  input  wire logic               step,
  input  wire logic [BURST_W-1:0] seed,
  input  wire logic               burstMode,
  // Result
  output logic      [BURST_W-1:0] burstAddr
);

  logic [BURST_W-1:0] base;
  logic [BURST_W-1:0] count;
  logic [BURST_W-1:0] next_count;
  logic [BURST_W-1:0] linearAddr;
  logic [BURST_W-1:0] interAddr;

  // Two bits wrap by themselves after four beats
  assign next_count = count + 2'h1;
  assign linearAddr = base + count;                     // see (R16)
  assign interAddr  = base ^ count;                     // see (R16)
  assign burstAddr  = (burstMode == MODE_LINEAR) ?
                      linearAddr : interAddr;           // see (R10)

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      base  <= RST_BURST;
      count <= RST_BURST;
    end else if (load) begin
      base  <= seed;                                    // see (R16)
      count <= RST_BURST;
    end else if (step) begin
      count <= next_count;                              // see (R14)
    end
  end

endmodule

// ---- hdl/ftsr_scan_port.sv ----
module ftsr_scan_port
  import ftsr_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Scan pins
  input  wire logic testClock,
  input  wire logic testModeSelect,
  input  wire logic testDataIn,
  output logic      testDataOut,
  output logic      testDataOutOe
);

  logic [SCN_N-1:0] scanMeta;
  logic [SCN_N-1:0] scanSync;
  logic             tckLast;
  logic             tckRise;
  logic             tckFall;
  logic             tmsSample;
  logic             tdiSample;

  // Pins come from another clock: two stages first
  assign tckRise = scanSync[SCN_TCK] & ~tckLast;
  assign tckFall = ~scanSync[SCN_TCK] & tckLast;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scanMeta <= RST_SCAN;
      scanSync <= RST_SCAN;
      tckLast  <= RST_LOW;
    end else begin
      scanMeta <= {testDataIn, testModeSelect, testClock};
      scanSync <= scanMeta;
      tckLast  <= scanSync[SCN_TCK];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tmsSample <= RST_HIGH;
      tdiSample <= RST_LOW;
    end else if (tckRise) begin
      tmsSample <= scanSync[SCN_TMS];                   // see (R12)
      tdiSample <= scanSync[SCN_TDI];                   // see (R12)
    end
  end

  // One-bit bypass path; driven only while mode select was low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      testDataOut   <= RST_LOW;
      testDataOutOe <= RST_LOW;
    end else if (tckFall) begin
      testDataOut   <= tdiSample;                       // see (R11)
      testDataOutOe <= ~tmsSample;                      // see (R11)
    end
  end

endmodule

// ---- hdl/ftsr_io_control.sv ----
// Function
// (R1) Rising edges count only while the clock qualifier is low.
// (R2) Qualifier high stretches the previous cycle, never deselects.
// (R3) Sleep request high enters low-power sleep, contents kept.
// (R4) Controller holds sleep request low or open for normal use.
// (R5) Input data lines are captured on the rising clock edge.
// (R6) Read data come straight from the addressed cell, no output stage.
// (R7) Output drive enable low drives data and parity, high floats them.
// (R8) Outputs float in write data phase, after deselect, when deselected.
// (R9) Parity acts as data; stored only with its lane's byte select.
// (R10) Strap low gives linear burst order, high or open interleaved.
// (R11) Scan serial output changes on the test clock falling edge.
// (R12) Scan data in and mode select are sampled on test clock rise.
// (R13) Qualifier high keeps every internal state unchanged; here the sleep sequencer still advances while it is high.
// (R14) Advance high on a qualified edge steps the burst counter.
// (R15) Controller drives write strobe low on a qualified edge to write.
// (R16) Low two address bits seed a two-bit burst counter.
//
module ftsr_io_control
  import ftsr_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // Synchronous control
  input  wire logic              clockQualifierN,
  input  wire logic              advanceLoad,
  input  wire logic              writeEnableN,
  input  wire logic [LANES-1:0]  byteWriteSelectN,
  input  wire logic              chipSelect1N,
  input  wire logic              chipSelect2,
  input  wire logic              chipSelect3N,
  input  wire logic [ADDR_W-1:0] address,
  // Asynchronous control and strap
  input  wire logic              outputDriveN,
  input  wire logic              sleepRequest,
  input  wire logic              burstModeStrap,
  // Data lines
  input  wire logic [DATA_W-1:0] dataIn,
  output logic      [DATA_W-1:0] dataOut,
  output logic                   dataOe,
  // Parity lines
  input  wire logic [LANES-1:0]  parityLinesIn,
  output logic      [LANES-1:0]  parityLinesOut,
  output logic                   parityLinesOe,
  // Status
  output logic                   lowPower,
  // Boundary scan
  input  wire logic              testClock,
  input  wire logic              testModeSelect,
  input  wire logic              testDataIn,
  output logic                   testDataOut,
  output logic                   testDataOutOe
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for the asynchronous pins

  logic [ASY_N-1:0] asyMeta;
  logic [ASY_N-1:0] asySync;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      asyMeta <= RST_ASYNC;
      asySync <= RST_ASYNC;
    end else begin
      asyMeta <= {burstModeStrap, outputDriveN, sleepRequest};
      asySync <= asyMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sleep sequencer: two cycles to enter, two to leave

  ftsr_sleep_t sleepState;
  ftsr_sleep_t next_sleepState;
  logic        sleepSync;
  logic        awake;

  assign sleepSync = asySync[ASY_SLEEP];
  assign awake     = (sleepState == SLP_AWAKE);

  always_comb begin
    next_sleepState = sleepState;
    case (sleepState)
      SLP_AWAKE: begin
        if (sleepSync) begin
          next_sleepState = SLP_ENTER;                  // see (R3)
        end
      end
      SLP_ENTER: begin
        next_sleepState = SLP_ASLEEP;
      end
      SLP_ASLEEP: begin
        if (!sleepSync) begin
          next_sleepState = SLP_EXIT;
        end
      end
      SLP_EXIT: begin
        next_sleepState = SLP_AWAKE;
      end
      default: begin
        next_sleepState = SLP_AWAKE;
      end
    endcase
  end

  // Pending accesses are dropped, the array itself is never touched
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sleepState <= SLP_AWAKE;
      lowPower   <= RST_LOW;
    end else begin
      sleepState <= next_sleepState;                    // see (R3)
      lowPower   <= (next_sleepState == SLP_ASLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  logic qualEdge;
  logic cmdEdge;
  logic allSelected;
  logic loadCmd;
  logic stepCmd;
  logic newAccess;

  assign qualEdge    = ~clockQualifierN;                // see (R1)
  assign cmdEdge     = qualEdge & awake;
  assign allSelected = ~chipSelect1N & chipSelect2 & ~chipSelect3N;
  assign loadCmd     = cmdEdge & ~advanceLoad;
  assign stepCmd     = cmdEdge & advanceLoad;           // see (R14)
  assign newAccess   = loadCmd & allSelected;

  ////////////////////////////////////////////////////////////////////////
  // Access state; frozen whole while the qualifier is high

  logic                 active;
  logic                 isWrite;
  logic [LANES-1:0]     byteSel;
  logic [ADDR_W-3:0]    addrHi;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      active  <= RST_ACTIVE;
      isWrite <= RST_WRITE;
      byteSel <= RST_BYTE_SEL;
      addrHi  <= RST_ADDR_HI;
    end else if (qualEdge) begin                        // see (R2) (R13)
      if (!awake) begin
        active <= RST_ACTIVE;
      end else if (loadCmd) begin
        active  <= allSelected;
        byteSel <= byteWriteSelectN;
        if (allSelected) begin
          isWrite <= ~writeEnableN;
          addrHi  <= address[ADDR_W-1:BURST_W];
        end
      end else begin
        // Burst beat: type kept, fresh lane selects per beat
        byteSel <= byteWriteSelectN;                    // see (R9)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst address

  logic [BURST_W-1:0] burstAddr;
  logic [ADDR_W-1:0]  memIndex;

  ftsr_burst_ctr u_burst (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .load      (newAccess),
    .step      (stepCmd),
    .seed      (address[BURST_W-1:0]),
    .burstMode (asySync[ASY_MODE]),
    .burstAddr (burstAddr)
  );

  assign memIndex = {addrHi, burstAddr};

  ////////////////////////////////////////////////////////////////////////
  // Storage, one cell of data and parity per lane

  logic                  writeData;
  logic [CELL_W-1:0]     laneRead [LANES];

  // The old index is used: the counter steps on this same edge
  assign writeData = cmdEdge & active & isWrite;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : gLane
      logic [CELL_W-1:0] laneMem [DEPTH];

      always_ff @(posedge ref_clk) begin
        if (writeData && !byteSel[g]) begin
          laneMem[memIndex] <= {parityLinesIn[g],
                                dataIn[g*LANE_W +: LANE_W]}; // see (R5) (R9)
        end
      end

      assign laneRead[g] = laneMem[memIndex];
      assign dataOut[g*LANE_W +: LANE_W] = laneRead[g][LANE_W-1:0]; // see (R6)
      assign parityLinesOut[g] = laneRead[g][LANE_W];   // see (R9)
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Output drive; the enable pin costs two cycles of latency

  logic readPhase;
  logic drive;

  assign readPhase     = active & ~isWrite & awake;     // see (R8)
  assign drive         = readPhase & ~asySync[ASY_OE];  // see (R7)
  assign dataOe        = drive;
  assign parityLinesOe = drive;                         // see (R9)

  ////////////////////////////////////////////////////////////////////////
  // Boundary scan pins

  ftsr_scan_port u_scan (
    .ref_clk        (ref_clk),
    .nrst           (nrst),
    .testClock      (testClock),
    .testModeSelect (testModeSelect),
    .testDataIn     (testDataIn),
    .testDataOut    (testDataOut),
    .testDataOutOe  (testDataOutOe)
  );

endmodule

// ---- dv/ftsr_io_checker.sv ----
module ftsr_io_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Control pins
  input wire logic clockQualifierN,
  input wire logic advanceLoad,
  input wire logic writeEnableN,
  input wire logic chipSelect1N,
  input wire logic chipSelect2,
  input wire logic chipSelect3N,
  input wire logic outputDriveN,
  input wire logic sleepRequest,
  input wire logic testClock,
  // Watched outputs
  input wire logic dataOe,
  input wire logic parityLinesOe,
  input wire logic lowPower,
  input wire logic testDataOut,
  input wire logic testDataOutOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////////
  wire selAll = !chipSelect1N && chipSelect2 && !chipSelect3N;
  wire load   = !clockQualifierN && !advanceLoad;
  sequence writeLoad; load && selAll && !writeEnableN; endsequence
  sequence readLoad; load && selAll && writeEnableN; endsequence
  // Both async pins pass two flops, so wait them out
  sequence quiet; (!outputDriveN && !sleepRequest) [*8]; endsequence
  sequence steady; ($stable(outputDriveN) && $stable(sleepRequest)) [*3];
  endsequence
  //////////////////////////////////////////////////////////////////////////
  a_write_dark: assert property (writeLoad |=> !dataOe)
    else $error("driving in write data phase");
  a_desel_dark: assert property (load && !selAll |=> !dataOe)
    else $error("driving after deselect");
  a_read_drive: assert property (quiet ##0 readLoad |=> dataOe)
    else $error("read data not driven");
  a_oe_float: assert property (outputDriveN [*3] |-> !dataOe)
    else $error("driving with output drive off");
  a_parity_twin: assert property (dataOe == parityLinesOe)
    else $error("parity enable differs from data");
  a_freeze_hold: assert property (steady ##0 clockQualifierN
    |=> $stable(dataOe)) else $error("state moved while frozen");
  a_sleep_enter: assert property (sleepRequest [*6] |-> lowPower)
    else $error("sleep not entered");
  a_sleep_exit: assert property (!sleepRequest [*6] |-> !lowPower)
    else $error("sleep not left");
  a_scan_fall: assert property (
    $changed({testDataOut, testDataOutOe}) |-> !testClock)
    else $error("scan output moved with clock high");
endmodule

bind ftsr_io_control ftsr_io_checker chk_u (.*);

// ---- dv/ftsr_ctl_model.sv ----
module ftsr_ctl_model
  import ftsr_pkg::*;
(
  // Clock
  input  wire logic                    ref_clk,
  // Controller drive
  input  wire logic [DATA_W+LANES-1:0] ctlData,
  input  wire logic                    ctlOe,
  // Device side of the lines
  input  wire logic [DATA_W-1:0]       dataOut,
  input  wire logic [LANES-1:0]        parityLinesOut,
  input  wire logic                    dataOe,
  input  wire logic                    parityLinesOe,
  output logic      [DATA_W-1:0]       dataIn,
  output logic      [LANES-1:0]        parityLinesIn,
  output logic                         clash
);
  logic [DATA_W+LANES-1:0] last = '0;
  //////////////////////////////////////////////////////////////////////////
  // Released lines flip, so a stale level never looks like good data
  assign dataIn = ctlOe ? ctlData[DATA_W-1:0] :
                  dataOe ? dataOut : ~last[DATA_W-1:0];
  assign parityLinesIn = ctlOe ? ctlData[DATA_W+LANES-1:DATA_W] :
                  parityLinesOe ? parityLinesOut :
                  ~last[DATA_W+LANES-1:DATA_W];
  assign clash = ctlOe && (dataOe || parityLinesOe);
  always_ff @(posedge ref_clk) begin
    last <= {parityLinesIn, dataIn};
  end
endmodule

// ---- dv/ftsr_io_control_tb_top.sv ----
module ftsr_io_control_tb_top
  import ftsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    ref_clk = 1'h0, nrst = 1'h0;
  logic                    clockQualifierN = 1'h0, advanceLoad = 1'h0;
  logic                    writeEnableN = 1'h1, chipSelect1N = 1'h1;
  logic                    chipSelect2 = 1'h0, chipSelect3N = 1'h1;
  logic                    outputDriveN = 1'h0, sleepRequest = 1'h0;
  logic                    burstModeStrap = 1'h1, testClock = 1'h0;
  logic                    testModeSelect = 1'h0, testDataIn = 1'h0;
  logic                    ctlOe = 1'h0, clash, dataOe, parityLinesOe;
  logic                    lowPower, testDataOut, testDataOutOe;
  logic [LANES-1:0]        byteWriteSelectN = 4'hf;
  logic [LANES-1:0]        parityLinesIn, parityLinesOut;
  logic [ADDR_W-1:0]       address = '0;
  logic [DATA_W-1:0]       dataIn, dataOut;
  logic [DATA_W+LANES-1:0] ctlData = '0;
  int                      mismatches = 0, checks = 0;
  localparam logic [17:0] BASE = 18'h00100, WADR = 18'h00204;
  localparam logic [35:0] D0 = 36'h312345600, F0 = 36'h0aaaa5555;
  localparam logic [35:0] F1 = 36'hf0f0f0f0f, M1 = 36'h20000ff00;
  localparam logic [35:0] WEXP = (F0 & ~M1) | (F1 & M1);
  ftsr_io_control dut_u (.*);
  ftsr_ctl_model  ctl_u (.*);
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk36(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input logic adv, wen, sel, input logic [3:0] bw,
                    input logic [17:0] a, input logic [35:0] d, input logic drv);
    @(posedge ref_clk);
    advanceLoad <= adv;
    writeEnableN <= wen;
    chipSelect1N <= !sel;
    chipSelect2 <= sel;
    chipSelect3N <= !sel;
    byteWriteSelectN <= bw;
    address <= a;
    ctlData <= d;
    ctlOe <= drv;
  endtask
  task automatic idle(input int n);
    repeat (n) op(1'h0, 1'h1, 1'h0, 4'hf, '0, '0, 1'h0);
  endtask
  task automatic look(input logic [35:0] exp);
    #50;
    chk36({parityLinesOut, dataOut}, exp);
    chk1(dataOe, 1'h1);
    chk1(parityLinesOe, 1'h1);
  endtask
  task automatic readW();
    op(1'h0, 1'h1, 1'h1, 4'hf, WADR, '0, 1'h0);
    idle(1);
    look(WEXP);
  endtask
  task automatic waitLp(input logic exp);
    int k;
    for (k = 0; k < 20 && lowPower !== exp; k++) @(posedge ref_clk);
    if (k == 20) begin
      mismatches++;
      print_verdict();
    end
    chk1(lowPower, exp);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_bytes();
    op(1'h0, 1'h0, 1'h1, 4'h0, WADR, '0, 1'h0);
    op(1'h0, 1'h0, 1'h1, 4'hd, WADR, F0, 1'h1);
    op(1'h0, 1'h1, 1'h1, 4'hf, WADR, F1, 1'h1);
    idle(1);
    look(WEXP);
  endtask
  task automatic t_burst();
    op(1'h0, 1'h0, 1'h1, 4'h0, BASE | 18'h1, '0, 1'h0);
    for (int i = 0; i < 4; i++) begin
      op(i < 3, 1'h0, i < 3, 4'h0, BASE, D0 + 36'(i), 1'h1);
    end
    burstModeStrap <= MODE_LINEAR;
    idle(3);
    op(1'h0, 1'h1, 1'h1, 4'hf, BASE | 18'h2, '0, 1'h0);
    for (int i = 0; i < 4; i++) begin
      op(i < 3, 1'h1, i < 3, 4'hf, BASE, '0, 1'h0);
      look(D0 + 36'(((2 + i) & 3) ^ 1));
    end
    idle(1);
    #50;
    chk1(dataOe, 1'h0);
  endtask
  task automatic t_freeze();
    op(1'h0, 1'h1, 1'h1, 4'hf, BASE, '0, 1'h0);
    op(1'h1, 1'h1, 1'h1, 4'hf, BASE, '0, 1'h0);
    clockQualifierN <= 1'h1;
    repeat (5) @(posedge ref_clk);
    look(D0 + 36'h1);
    @(posedge ref_clk);
    clockQualifierN <= 1'h0;
    idle(1);
    look(D0);
    idle(1);
  endtask
  task automatic t_drive();
    outputDriveN <= 1'h1;
    idle(3);
    op(1'h0, 1'h1, 1'h1, 4'hf, WADR, '0, 1'h0);
    idle(1);
    #50;
    chk1(dataOe, 1'h0);
    chk1(parityLinesOe, 1'h0);
    @(posedge ref_clk);
    outputDriveN <= 1'h0;
    idle(3);
    readW();
  endtask
  task automatic t_sleep();
    @(posedge ref_clk);
    sleepRequest <= 1'h1;
    waitLp(1'h1);
    idle(4);
    sleepRequest <= 1'h0;
    waitLp(1'h0);
    idle(8);
    readW();
  endtask
  task automatic t_scan();
    logic p;
    p = 1'h0;
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      testModeSelect <= i[0];
      testDataIn <= i[1];
      repeat (8) @(posedge ref_clk);
      testClock <= 1'h1;
      repeat (8) @(posedge ref_clk);
      chk1(testDataOut, p);
      testClock <= 1'h0;
      repeat (8) @(posedge ref_clk);
      chk1(testDataOut, i[1]);
      chk1(testDataOutOe, !i[0]);
      p = i[1];
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Any overlap of both drivers on the shared lines is a fault
  always @(negedge ref_clk) begin
    if (nrst) chk1(clash, 1'h0);
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'h1;
    idle(2);
    t_bytes();
    t_burst();
    t_freeze();
    t_drive();
    t_sleep();
    t_scan();
    print_verdict();
  end
endmodule
